// file: flash_host_pkg.sv
// Package for the parallel flash host controller: timing, command words and types
// Function
// - Command writes drive write-enable and chip-select low with output-enable high.
// - Host flags an operation that a reset interrupted on opInterrupted; the caller reissues it.
// - Host lowers chip-select only after reset has returned high.
// - Host waits the reset-to-read delay after reset rises before reading.
`default_nettype none
package flash_host_pkg;
	localparam int CLK_NS = 40;
	// Timing in ns as the device needs it, converted to cycles
	localparam int ACCESS_NS = 70;
	localparam int WE_PULSE_NS = 35;
	localparam int SETUP_NS = 30;
	localparam int RESET_PULSE_MIN_NS = 500;
	localparam int RESET_TO_READ_DELAY_NS = 50;
	localparam int RESET_HOLD_CYC = (RESET_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int RECOVER_CYC = (RESET_TO_READ_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int PULSE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	// Cycles lost in the two-flop synchronisers on data and ready/busy
	localparam int SYNC_CYC = 2;
	localparam int CNT_W = 8;
	// Command words (unlock addresses and codes)
	localparam logic [19:0] UNLOCK_A1 = 20'h00555;
	localparam logic [19:0] UNLOCK_A2 = 20'h002AA;
	localparam logic [15:0] UNLOCK_D1 = 16'h00AA;
	localparam logic [15:0] UNLOCK_D2 = 16'h0055;
	localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
	localparam logic [15:0] CMD_ERASE = 16'h0080;
	localparam logic [15:0] CMD_SECTOR = 16'h0030;
	localparam logic [15:0] CMD_CHIP = 16'h0010;
	localparam logic [15:0] CMD_BYPASS = 16'h0020;
	localparam logic [15:0] CMD_IDENT = 16'h0090;
	localparam logic [15:0] CMD_RESET = 16'h00F0;
	localparam logic [15:0] CMD_EXIT1 = 16'h0090;
	localparam logic [15:0] CMD_EXIT2 = 16'h0000;
	localparam logic [7:0] DQ_BUSY_MASK = 8'h40;
	// Host operations
	typedef enum logic [3:0] {
		OP_READ = 4'h0,
		OP_PROGRAM = 4'h1,
		OP_ERASE_SECTOR = 4'h2,
		OP_ERASE_CHIP = 4'h3,
		OP_IDENT = 4'h4,
		OP_BYPASS_ENTER = 4'h5,
		OP_BYPASS_EXIT = 4'h6,
		OP_RESET_CMD = 4'h7,
		OP_HW_RESET = 4'h8
	} op_t;
	typedef struct packed {
		op_t op;
		logic byteMode;
		logic [19:0] addr;
		logic [15:0] data;
		logic moreSectors;
	} req_t;
	// One bus cycle toward the device
	typedef struct packed {
		logic write;
		logic [19:0] addr;
		logic [15:0] data;
	} cyc_t;
	typedef struct packed {
		logic ceN;
		logic oeN;
		logic weN;
		logic resetN;
		logic byteN;
		logic [19:0] addr;
		logic [15:0] dqOut;
		logic [15:0] dqOe;
	} pins_t;
endpackage
`default_nettype wire

// file: flash_sector_decode.sv
// Top-boot sector index decode from the upper array address bits
`default_nettype none
module flash_sector_decode (
	input wire logic [6:0] hiAddr,
	output logic [4:0] sector
);
	// Only bits 18..12 select a sector; low bits ignored
	always_comb begin
		if (hiAddr[6:3] != 4'hF) begin
			sector = {1'b0, hiAddr[6:3]};
		end else if (!hiAddr[2]) begin
			sector = 5'h0F;
		end else if (hiAddr[1]) begin
			sector = 5'h12;
		end else begin
			sector = hiAddr[0] ? 5'h11 : 5'h10;
		end
	end
endmodule
`default_nettype wire

// file: flash_host.sv
// Host controller driving a parallel NOR flash through its pins
`default_nettype none
module flash_host (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reqValid,
	input wire flash_host_pkg::req_t req,
	output logic reqReady,
	output logic rspValid,
	output logic [15:0] rspData,
	output logic [4:0] rspSector,
	output logic bypassActive,
	output logic opInterrupted,
	output logic flashCeN,
	output logic flashOeN,
	output logic flashWeN,
	output logic flashResetN,
	output logic flashByteN,
	output logic [19:0] flashAddr,
	output logic [15:0] dqOut,
	output logic [15:0] dqOe,
	input wire logic [15:0] dqIn,
	input wire logic readyBusyN
);
	import flash_host_pkg::*;

	typedef enum logic [8:0] {
		ST_RESET = 9'h001,
		ST_RECOVER = 9'h002,
		ST_IDLE = 9'h004,
		ST_SETUP = 9'h008,
		ST_PULSE = 9'h010,
		ST_HOLD = 9'h020,
		ST_READ = 9'h040,
		ST_POLL = 9'h080,
		ST_DONE = 9'h100
	} state_t;

	state_t state_r, state_nxt;
	pins_t pins_r, pins_nxt;
	req_t cur_r, cur_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [2:0] step_r, step_nxt;
	logic bypass_r, bypass_nxt;
	logic intr_r, intr_nxt;
	logic busyOp_r, busyOp_nxt;
	logic rspValid_r, rspValid_nxt;
	logic [15:0] rspData_r, rspData_nxt;
	logic [4:0] rspSector_r, rspSector_nxt;
	logic [15:0] dqMeta_r, dqSync_r;
	logic rbMeta_r, rbSync_r;
	logic [4:0] sectorIdx;
	cyc_t cyc;
	logic [2:0] lastStep;
	logic [15:0] dqMask;

	// Pin inputs pass two flops before use
	always_ff @(posedge sys_clk) begin
		dqMeta_r <= dqIn;
		dqSync_r <= dqMeta_r;
		rbMeta_r <= readyBusyN;
		rbSync_r <= rbMeta_r;
	end

	flash_sector_decode u_decode (
		.hiAddr(cur_r.addr[18:12]),
		.sector(sectorIdx)
	);

	// Step table: the cycle of the current operation at step_r
	always_comb begin
		cyc = '{write: 1'b1, addr: UNLOCK_A1, data: UNLOCK_D1};
		lastStep = 3'd0;
		case (cur_r.op)
			OP_PROGRAM: begin
				if (bypass_r) begin
					lastStep = 3'd1; // Two cycles in bypass
					if (step_r == 3'd0) cyc.data = CMD_PROGRAM;
					else cyc = '{write: 1'b1, addr: cur_r.addr, data: cur_r.data};
				end else begin
					lastStep = 3'd3; // Four cycles otherwise
					if (step_r == 3'd1) cyc = '{write: 1'b1, addr: UNLOCK_A2, data: UNLOCK_D2};
					if (step_r == 3'd2) cyc.data = CMD_PROGRAM;
					if (step_r == 3'd3) cyc = '{write: 1'b1, addr: cur_r.addr, data: cur_r.data};
				end
			end
			OP_ERASE_SECTOR, OP_ERASE_CHIP: begin
				lastStep = 3'd5; // Six cycles; extra sectors reuse the last
				if (step_r == 3'd1 || step_r == 3'd4)
					cyc = '{write: 1'b1, addr: UNLOCK_A2, data: UNLOCK_D2};
				if (step_r == 3'd2) cyc.data = CMD_ERASE;
				if (step_r == 3'd5) begin
					if (cur_r.op == OP_ERASE_CHIP) cyc.data = CMD_CHIP;
					else cyc = '{write: 1'b1, addr: cur_r.addr, data: CMD_SECTOR};
				end
			end
			OP_IDENT, OP_BYPASS_ENTER: begin
				lastStep = 3'd2;
				if (step_r == 3'd1) cyc = '{write: 1'b1, addr: UNLOCK_A2, data: UNLOCK_D2};
				if (step_r == 3'd2) cyc.data = (cur_r.op == OP_IDENT) ? CMD_IDENT : CMD_BYPASS;
			end
			OP_BYPASS_EXIT: begin
				lastStep = 3'd1;
				cyc.data = (step_r == 3'd0) ? CMD_EXIT1 : CMD_EXIT2;
			end
			OP_RESET_CMD: cyc.data = CMD_RESET;
			default: cyc = '{write: 1'b0, addr: cur_r.addr, data: 16'h0000};
		endcase
		// Byte mode: DATA_MSB_OR_LOW_ADDR carries the extra low address bit, DQ8..14 idle
		if (cur_r.byteMode && cyc.write && (cyc.addr != cur_r.addr || cur_r.op != OP_PROGRAM))
			cyc.addr = {cyc.addr[18:0], 1'b0};
	end

	assign dqMask = cur_r.byteMode ? 16'h80FF : 16'hFFFF;

	// Main sequencer
	always_comb begin
		state_nxt = state_r;
		pins_nxt = pins_r;
		cur_nxt = cur_r;
		cnt_nxt = (cnt_r != '0) ? cnt_r - CNT_W'(1) : cnt_r;
		step_nxt = step_r;
		bypass_nxt = bypass_r;
		intr_nxt = intr_r;
		busyOp_nxt = busyOp_r;
		rspValid_nxt = 1'b0;
		rspData_nxt = rspData_r;
		rspSector_nxt = rspSector_r;
		case (state_r)
			ST_RESET: begin
				// Hold reset low the minimum pulse; CE stays high
				pins_nxt = '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, resetN: 1'b0, byteN: 1'b1,
					addr: 20'h00000, dqOut: 16'h0000, dqOe: 16'h0000};
				if (cnt_r == '0) begin
					pins_nxt.resetN = 1'b1;
					cnt_nxt = CNT_W'(RECOVER_CYC);
					bypass_nxt = 1'b0; // Device back in array read
					state_nxt = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				// Wait recovery and ready/busy high before any access
				if (cnt_r == '0 && rbSync_r) begin
					if (cur_r.op == OP_HW_RESET) rspValid_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
			ST_IDLE: begin
				pins_nxt.ceN = 1'b1; // Standby while idle
				pins_nxt.oeN = 1'b1;
				pins_nxt.dqOe = 16'h0000;
				if (reqValid) begin
					cur_nxt = req;
					step_nxt = 3'd0;
					pins_nxt.byteN = ~req.byteMode;
					if (req.op == OP_HW_RESET) begin
						intr_nxt = busyOp_r; // Caller reissues interrupted work
						busyOp_nxt = 1'b0;
						cnt_nxt = CNT_W'(RESET_HOLD_CYC);
						state_nxt = ST_RESET;
					end else begin
						if (req.op != OP_READ) intr_nxt = 1'b0;
						state_nxt = ST_SETUP;
					end
				end
			end
			ST_SETUP: begin
				pins_nxt.addr = cyc.addr;
				if (cyc.write) begin
					// Command cycle: OE high, then CE and WE low
					pins_nxt.oeN = 1'b1;
					pins_nxt.ceN = 1'b0;
					pins_nxt.dqOut = cyc.data & dqMask;
					pins_nxt.dqOe = cur_r.byteMode ? 16'h00FF : 16'hFFFF;
					cnt_nxt = CNT_W'(SETUP_CYC);
					state_nxt = ST_PULSE;
				end else begin
					// Read from standby: wait full chip-select access
					pins_nxt.ceN = 1'b0;
					pins_nxt.oeN = 1'b0;
					pins_nxt.dqOe = 16'h0000;
					if (cur_r.byteMode) pins_nxt.addr = {1'b0, cur_r.addr[19:1]};
					if (cur_r.byteMode) pins_nxt.dqOut = {cur_r.addr[0], 15'h0000};
					if (cur_r.byteMode) pins_nxt.dqOe = 16'h8000;
					// Data must also cross the synchroniser before it is taken
					cnt_nxt = CNT_W'(ACCESS_CYC + SYNC_CYC);
					state_nxt = ST_READ;
				end
			end
			ST_PULSE: begin
				if (cnt_r == '0 && pins_r.weN) begin
					pins_nxt.weN = 1'b0; // Device latches on WE edges
					cnt_nxt = CNT_W'(PULSE_CYC);
				end else if (cnt_r == '0) begin
					pins_nxt.weN = 1'b1;
					state_nxt = ST_HOLD;
				end
			end
			ST_HOLD: begin
				pins_nxt.ceN = 1'b1;
				pins_nxt.dqOe = 16'h0000;
				if (step_r != lastStep) begin
					step_nxt = step_r + 3'd1;
					state_nxt = ST_SETUP;
				end else if ((cur_r.op == OP_ERASE_SECTOR) && cur_r.moreSectors) begin
					rspSector_nxt = sectorIdx;
					rspValid_nxt = 1'b1; // More sector addresses may follow
					state_nxt = ST_DONE;
				end else begin
					if (cur_r.op == OP_BYPASS_ENTER) bypass_nxt = 1'b1;
					if (cur_r.op == OP_BYPASS_EXIT || cur_r.op == OP_RESET_CMD) bypass_nxt = 1'b0;
					rspSector_nxt = sectorIdx;
					if (cur_r.op == OP_PROGRAM || cur_r.op == OP_ERASE_SECTOR ||
						cur_r.op == OP_ERASE_CHIP) begin
						busyOp_nxt = 1'b1;
						// Busy needs the synchroniser delay before it can be seen
						cnt_nxt = CNT_W'(ACCESS_CYC + SYNC_CYC);
						state_nxt = ST_POLL;
					end else begin
						rspValid_nxt = 1'b1;
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_DONE: begin
				// Next sector in the same erase: one more sector cycle
				if (reqValid && req.op == OP_HW_RESET) begin
					// Erase already runs in the device; flag it for reissue
					cur_nxt = req;
					intr_nxt = 1'b1;
					cnt_nxt = CNT_W'(RESET_HOLD_CYC);
					state_nxt = ST_RESET;
				end else if (reqValid && req.op == OP_ERASE_SECTOR) begin
					cur_nxt = req;
					step_nxt = 3'd5;
					state_nxt = ST_SETUP;
				end else if (reqValid || cur_r.moreSectors) begin
					busyOp_nxt = 1'b1;
					cur_nxt.moreSectors = 1'b0;
					cnt_nxt = CNT_W'(ACCESS_CYC + SYNC_CYC);
					state_nxt = ST_POLL;
				end
			end
			ST_READ: begin
				if (cnt_r == '0) begin
					// Identification and status land on the low byte
					rspData_nxt = cur_r.byteMode ? {8'h00, dqSync_r[7:0]} : dqSync_r;
					rspValid_nxt = 1'b1;
					pins_nxt.oeN = 1'b1; // Device floats outputs with OE high
					pins_nxt.ceN = 1'b1;
					pins_nxt.dqOe = 16'h0000;
					state_nxt = ST_IDLE;
				end
			end
			ST_POLL: begin
				// CE released between polls; operation runs on
				pins_nxt.ceN = 1'b1;
				pins_nxt.oeN = 1'b1;
				if (cnt_r == '0 && rbSync_r) begin
					busyOp_nxt = 1'b0;
					rspData_nxt = {8'h00, dqSync_r[7:0] & DQ_BUSY_MASK};
					rspValid_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// Registers; reset starts with a device reset pulse
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_r <= ST_RESET;
			pins_r <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, resetN: 1'b0, byteN: 1'b1,
				addr: 20'h00000, dqOut: 16'h0000, dqOe: 16'h0000};
			cur_r <= '{op: OP_READ, byteMode: 1'b0, addr: 20'h00000, data: 16'h0000,
				moreSectors: 1'b0};
			cnt_r <= CNT_W'(RESET_HOLD_CYC);
			step_r <= 3'd0;
			bypass_r <= 1'b0;
			intr_r <= 1'b0;
			busyOp_r <= 1'b0;
			rspValid_r <= 1'b0;
			rspData_r <= 16'h0000;
			rspSector_r <= 5'h00;
		end else begin
			state_r <= state_nxt;
			pins_r <= pins_nxt;
			cur_r <= cur_nxt;
			cnt_r <= cnt_nxt;
			step_r <= step_nxt;
			bypass_r <= bypass_nxt;
			intr_r <= intr_nxt;
			busyOp_r <= busyOp_nxt;
			rspValid_r <= rspValid_nxt;
			rspData_r <= rspData_nxt;
			rspSector_r <= rspSector_nxt;
		end
	end

	logic reqReady_r;
	// Ready registered: high in idle and in the extra-sector wait
	always_ff @(posedge sys_clk) begin
		if (rst) reqReady_r <= 1'b0;
		else reqReady_r <= (state_nxt == ST_IDLE) || (state_nxt == ST_DONE);
	end

	assign reqReady = reqReady_r;
	assign rspValid = rspValid_r;
	assign rspData = rspData_r;
	assign rspSector = rspSector_r;
	assign bypassActive = bypass_r;
	assign opInterrupted = intr_r;
	assign flashCeN = pins_r.ceN;
	assign flashOeN = pins_r.oeN;
	assign flashWeN = pins_r.weN;
	assign flashResetN = pins_r.resetN;
	assign flashByteN = pins_r.byteN;
	assign flashAddr = pins_r.addr;
	assign dqOut = pins_r.dqOut;
	assign dqOe = pins_r.dqOe;
endmodule
`default_nettype wire

// file: flash_host_properties.sv
// Concurrent checks on the flash host pins
`default_nettype none
module flash_host_properties (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reqReady,
	input wire logic flashCeN,
	input wire logic flashOeN,
	input wire logic flashWeN,
	input wire logic flashResetN,
	input wire logic flashByteN,
	input wire logic [15:0] dqOe
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// Pin relations; bus contention is caught where the host drives DQ0..14 during a read
	AST_WRITE_LEVELS: assert property (!flashWeN |-> !flashCeN && flashOeN)
		else $error("write strobe without select");
	AST_SELECT_IN_RESET: assert property (!flashResetN |-> flashCeN)
		else $error("select low while reset low");
	AST_RESET_WIDTH: assert property ($fell(flashResetN) |-> !flashResetN [*8])
		else $error("reset pulse too short");
	AST_RECOVERY: assert property ($rose(flashResetN) |-> (flashOeN && !reqReady) [*2])
		else $error("read too soon after reset");
	AST_READ_HOLD: assert property ($fell(flashOeN) |-> (!flashOeN && !flashCeN) [*2])
		else $error("read shorter than access time");
	AST_NO_CONTENTION: assert property (!flashOeN |-> (dqOe & 16'h7FFF) == 16'h0000)
		else $error("host drives data during read");
	AST_BYTE_A1: assert property (!flashOeN && !flashByteN |-> dqOe[15])
		else $error("lowest address bit not driven");
	AST_WE_PULSE: assert property ($fell(flashWeN) |-> ##[1:4] flashWeN)
		else $error("write strobe stuck low");
endmodule
bind flash_host flash_host_properties flash_host_properties_inst (.sys_clk(sys_clk), .rst(rst),
	.reqReady(reqReady), .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
	.flashResetN(flashResetN), .flashByteN(flashByteN), .dqOe(dqOe));
`default_nettype wire

// file: flash_model.sv
// Behavioural parallel flash device facing the host controller
`default_nettype none
module flash_model #(
	parameter logic [7:0] ID_MAKER = 8'h3C, // Arbitrary code
	parameter int ACC_NS = 70,
	parameter int READY_NS = 800
) (
	input wire logic ceN,
	input wire logic oeN,
	input wire logic weN,
	input wire logic resetN,
	input wire logic byteN,
	input wire logic [19:0] addr,
	input wire logic [15:0] dqOut,
	input wire logic [15:0] dqOe,
	output logic [15:0] dqBus,
	output logic readyBusyN
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [logic [18:0]];
	logic [4:0] secQ [$];
	logic [15:0] pat = 16'h5A5A, w, devOe;
	logic [7:0] d;
	logic idn = 1'b0, byp = 1'b0;
	int st = 0, gen = 0, weCount = 0;
	time tChg = 0;
	initial readyBusyN = 1'b1;
	// Sector from upper bits only, top-boot map
	function automatic logic [4:0] sec(input logic [18:0] a);
		if (a[18:15] != 4'hF) return {1'b0, a[18:15]};
		return a[14] ? (a[13] ? 5'h12 : 5'h10 + 5'(a[12])) : 5'h0F;
	endfunction
	// Result lands only if no reset or restart overtook it, so deselect never aborts
	task automatic run(input int ns, input logic [18:0] a, input logic [15:0] v);
		int g;
		logic [18:0] del [$];
		gen++;
		g = gen;
		readyBusyN = 1'b0;
		#(ns);
		if (g == gen) begin
			if (v !== 16'hFFFF) mem[a] = (mem.exists(a) ? mem[a] : 16'hFFFF) & v;
			foreach (mem[k]) if (v === 16'hFFFF && (secQ.size() == 0 || sec(k) inside {secQ}))
				del.push_back(k);
			foreach (del[j]) mem.delete(del[j]);
			secQ.delete();
			st = 0;
			readyBusyN = 1'b1;
		end
	endtask
	// Commands latch on the closing strobe edge; program and erase change the array map only after the run delay
	always @(posedge weN or posedge ceN) begin
		d = dqBus[7:0];
		if (resetN && oeN && (weN ^ ceN)) begin
			weCount++;
			case (st)
			0: begin
				idn = idn & (d != 8'hF0);
				st = (byp && d == 8'hA0) ? 3 : (byp && d == 8'h90) ? 7 : (d == 8'hAA) ? 1 : 0;
			end
			1: st = (d == 8'h55) ? 2 : 0;
			2: begin
				st = (d == 8'hA0) ? 3 : (d == 8'h80) ? 4 : 0;
				idn = idn | (d == 8'h90);
				byp = byp | (d == 8'h20);
			end
			3: begin
				st = 8;
				fork run(400, addr[18:0], dqBus); join_none
			end
			4: st = (d == 8'hAA) ? 5 : 0;
			5: st = (d == 8'h55) ? 6 : 0;
			6: if (d == 8'h30 || d == 8'h10) begin
				if (d == 8'h30) secQ.push_back(sec(addr[18:0]));
				fork run(2000, 19'h00000, 16'hFFFF); join_none
			end else st = 0;
			7: begin
				byp = (d != 8'h00);
				st = 0;
			end
			default: ;
			endcase
		end
	end
	// Reset aborts, returns to array read; busy line clears after the ready time
	always @(negedge resetN) begin
		gen++;
		st = 0;
		idn = 1'b0;
		byp = 1'b0;
		secQ.delete();
		readyBusyN <= #(READY_NS) 1'b1;
	end
	always #10 pat = ~pat;
	always @(ceN, oeN, addr, resetN, byteN) tChg = $time;
	// Outputs only when selected, enabled, out of reset and past access time; else float
	always @* begin
		w = idn ? {8'h00, ID_MAKER} : !readyBusyN ? 16'h0040 :
			mem.exists(addr[18:0]) ? mem[addr[18:0]] : 16'hFFFF;
		if (!byteN) w = {8'h00, (dqOe[15] ? dqOut[15] : pat[15]) ? w[15:8] : w[7:0]};
		devOe = (!ceN && !oeN && weN && resetN && $time - tChg >= ACC_NS) ?
			{{8{byteN}}, 8'hFF} : 16'h0000;
		dqBus = (dqOe & dqOut) | (~dqOe & devOe & w) | (~dqOe & ~devOe & pat);
	end
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the parallel flash host controller
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import flash_host_pkg::*;
	logic sys_clk = 1'b0, rst = 1'b1, reqValid = 1'b0;
	req_t req = '0;
	logic reqReady, rspValid, bypassActive, opInterrupted, ceN, oeN, weN, resN, byteN, rdy;
	logic [15:0] rspData, dqOut, dqOe, dqBus;
	logic [4:0] rspSector;
	logic [19:0] fAddr;
	int mismatches = 0, cmpCount = 0, c;
	flash_host flash_host_inst (.sys_clk(sys_clk), .rst(rst), .reqValid(reqValid), .req(req),
		.reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .rspSector(rspSector),
		.bypassActive(bypassActive), .opInterrupted(opInterrupted), .flashCeN(ceN),
		.flashOeN(oeN), .flashWeN(weN), .flashResetN(resN), .flashByteN(byteN),
		.flashAddr(fAddr), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqBus), .readyBusyN(rdy));
	flash_model flash_model_inst (.ceN(ceN), .oeN(oeN), .weN(weN), .resetN(resN),
		.byteN(byteN), .addr(fAddr), .dqOut(dqOut), .dqOe(dqOe), .dqBus(dqBus), .readyBusyN(rdy));
	initial forever #20 sys_clk = ~sys_clk;
	task automatic give_verdict();
		if (mismatches == 0 && cmpCount > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmpCount++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One request, held until taken, then wait for its answer pulse; entered at a falling edge
	task automatic op(input op_t o, input logic bm, input logic [19:0] a, input logic [15:0] v,
		input logic more);
		int n;
		n = 0;
		req = '{o, bm, a, v, more};
		reqValid = 1'b1;
		while (reqReady !== 1'b1 && n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
		@(negedge sys_clk);
		reqValid = 1'b0;
		while (rspValid !== 1'b1 && n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
		chk("handshake timeout", 16'h0000, {15'h0000, n >= 3000});
	endtask
	task automatic test_program();
		c = flash_model_inst.weCount;
		op(OP_PROGRAM, 1'b0, 20'h7C123, 16'hA55A, 1'b0);
		chk("program cycles", 16'h0004, 16'(flash_model_inst.weCount - c));
		chk("program sector", 16'h0010, {11'h000, rspSector});
		op(OP_READ, 1'b0, 20'h7C123, 16'h0000, 1'b0);
		chk("program data", 16'hA55A, rspData);
		op(OP_READ, 1'b1, {19'h7C123, 1'b1}, 16'h0000, 1'b0);
		chk("byte high", 16'h00A5, {8'h00, rspData[7:0]});
		op(OP_READ, 1'b1, {19'h7C123, 1'b0}, 16'h0000, 1'b0);
		chk("byte low", 16'h005A, {8'h00, rspData[7:0]});
	endtask
	task automatic test_bypass();
		op(OP_BYPASS_ENTER, 1'b0, 20'h00000, 16'h0000, 1'b0);
		chk("bypass on", 16'h0001, {15'h0000, bypassActive});
		c = flash_model_inst.weCount;
		op(OP_PROGRAM, 1'b0, 20'h7D010, 16'h1234, 1'b0);
		chk("bypass cycles", 16'h0002, 16'(flash_model_inst.weCount - c));
		op(OP_BYPASS_EXIT, 1'b0, 20'h00000, 16'h0000, 1'b0);
		chk("bypass off", 16'h0000, {15'h0000, bypassActive});
	endtask
	// Two sectors in one erase, low address bits differing from the programmed words
	task automatic test_erase();
		op(OP_PROGRAM, 1'b0, 20'h00200, 16'h0F0F, 1'b0);
		op(OP_ERASE_SECTOR, 1'b0, 20'h7CFFF, 16'h0000, 1'b1);
		chk("erase sector a", 16'h0010, {11'h000, rspSector});
		op(OP_ERASE_SECTOR, 1'b0, 20'h07ABC, 16'h0000, 1'b0);
		chk("erase sector b", 16'h0000, {11'h000, rspSector});
		op(OP_READ, 1'b0, 20'h7C123, 16'h0000, 1'b0);
		chk("erased word a", 16'hFFFF, rspData);
		op(OP_READ, 1'b0, 20'h00200, 16'h0000, 1'b0);
		chk("erased word b", 16'hFFFF, rspData);
		op(OP_READ, 1'b0, 20'h7D010, 16'h0000, 1'b0);
		chk("kept word", 16'h1234, rspData);
		op(OP_ERASE_CHIP, 1'b0, 20'h00000, 16'h0000, 1'b0);
		op(OP_READ, 1'b0, 20'h7D010, 16'h0000, 1'b0);
		chk("chip erased", 16'hFFFF, rspData);
	endtask
	task automatic test_ident_reset();
		op(OP_IDENT, 1'b0, 20'h00000, 16'h0000, 1'b0);
		op(OP_READ, 1'b0, 20'h00000, 16'h0000, 1'b0);
		chk("ident code", 16'h003C, {8'h00, rspData[7:0]});
		op(OP_HW_RESET, 1'b0, 20'h00000, 16'h0000, 1'b0);
		op(OP_READ, 1'b0, 20'h00000, 16'h0000, 1'b0);
		chk("array after reset", 16'hFFFF, rspData);
		chk("interrupted flag", 16'h0000, {15'h0000, opInterrupted});
	endtask
	// Reset lands while a sector erase runs; the word survives until the erase is reissued
	task automatic test_interrupt();
		op(OP_PROGRAM, 1'b0, 20'h7C123, 16'h1111, 1'b0);
		op(OP_ERASE_SECTOR, 1'b0, 20'h7C000, 16'h0000, 1'b1);
		op(OP_HW_RESET, 1'b0, 20'h00000, 16'h0000, 1'b0);
		chk("erase interrupted", 16'h0001, {15'h0000, opInterrupted});
		op(OP_READ, 1'b0, 20'h7C123, 16'h0000, 1'b0);
		chk("aborted erase", 16'h1111, rspData);
		op(OP_ERASE_SECTOR, 1'b0, 20'h7C000, 16'h0000, 1'b0);
		op(OP_READ, 1'b0, 20'h7C123, 16'h0000, 1'b0);
		chk("reissued erase", 16'hFFFF, rspData);
		chk("flag cleared", 16'h0000, {15'h0000, opInterrupted});
	endtask
	initial begin
		repeat (4) @(negedge sys_clk);
		rst = 1'b0;
		op(OP_READ, 1'b0, 20'h00100, 16'h0000, 1'b0);
		chk("boot read", 16'hFFFF, rspData);
		test_program();
		test_bypass();
		test_erase();
		test_ident_reset();
		test_interrupt();
		give_verdict();
	end
	// Whole run needs about 700 cycles; this limit leaves wide margin
	initial begin
		#(20000 * 40);
		mismatches++;
		give_verdict();
	end
endmodule
`default_nettype wire
